// ### hdl/pdc_power_down.sv
// Power-down mode controller: standby control register, sleep and standby.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module pdc_power_down #(
   parameter int LEVEL_W = pdc_pkg::IRQ_LEVEL_W,
   parameter int PORT_W  = pdc_pkg::PORT_W
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [31:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   input  wire logic [3:0]         pstrb_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // CPU core
   input  wire logic               sleep_req_i,
   input  wire logic [LEVEL_W-1:0] status_mask_i,
   output logic                    irq_exc_start_o,
   output logic                    addr_err_exc_start_o,
   // Interrupt and transfer error sources
   input  wire logic               irq_req_i,
   input  wire logic [LEVEL_W-1:0] irq_level_i,
   input  wire logic               irq_src_enabled_i,
   input  wire logic               mac_addr_err_i,
   input  wire logic               data_transfer_ctrl_err_i,
   // Watchdog
   input  wire logic               watchdog_run_enable_i,
   // Reset pins
   input  wire logic               power_on_reset_n_i,
   input  wire logic               manual_reset_n_i,
   output logic                    power_on_reset_o,
   output logic                    manual_reset_o,
   // Power controls and mode
   output pdc_pkg::pdc_pwr_ctl_t   pwr_ctl_o,
   output pdc_pkg::pdc_mode_t      mode_o,
   // I/O port pins
   input  wire logic [PORT_W-1:0]  func_out_i,
   input  wire logic [PORT_W-1:0]  func_oe_i,
   output logic      [PORT_W-1:0]  pad_out_o,
   output logic      [PORT_W-1:0]  pad_oe_o
);
   import pdc_pkg::*;

   // Register state.
   logic       standby_select;
   logic       port_float_select;
   logic [3:0] last_wake;
   pdc_mode_t  mode;
   pdc_mode_t  next_mode;
   pdc_wake_t  wake;

   // Bus decode.
   logic       hit_ctrl;
   logic       hit_stat;
   logic       mapped;
   logic       setup_rd;
   logic       wr_ctrl;
   logic       rd_stat;
   logic [7:0] ctrl_view;
   logic [7:0] stat_view;

   // Mode events.
   logic       hard_reset;
   logic       leave_sleep;
   logic       enter_power_down;

   // Wake sources, qualified and ordered by priority.
   pdc_wake_detect #(
      .LEVEL_W            (LEVEL_W)
   ) u_wake (
      .irq_req_i          (irq_req_i),
      .irq_level_i        (irq_level_i),
      .irq_src_enabled_i  (irq_src_enabled_i),
      .status_mask_i      (status_mask_i),
      .mac_addr_err_i     (mac_addr_err_i),
      .data_transfer_ctrl_err_i (data_transfer_ctrl_err_i),
      .power_on_reset_n_i (power_on_reset_n_i),
      .manual_reset_n_i   (manual_reset_n_i),
      .wake_o             (wake)
   );

   // The power-on pin resets the mode, control bits, exception starts, power controls and port pins just like the system reset.
   assign hard_reset = rst_i || wake.power_on;

   // Address decode; the control register lives in byte lane 0.
   assign hit_ctrl = (paddr_i == STBY_CTRL_ADDR);
   assign hit_stat = (paddr_i == PWR_STAT_ADDR);
   assign mapped   = hit_ctrl || hit_stat;
   assign setup_rd = psel_i && !penable_i && !pwrite_i;
   assign wr_ctrl  = psel_i && penable_i && pwrite_i && hit_ctrl
                     && pstrb_i[0] && (mode != PDC_STANDBY);
   assign rd_stat  = psel_i && penable_i && !pwrite_i && hit_stat;

   // Zero wait states; unmapped addresses answer with an error.
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   // Reserved bits are forced on read, whatever is stored.
   always_comb begin
      ctrl_view                 = STBY_RSVD_VALUE;
      ctrl_view[STBY_SEL_BIT]   = standby_select;
      ctrl_view[PORT_FLOAT_BIT] = port_float_select;
   end

   // Status view: current mode and the cause of the last wake-up.
   always_comb begin
      stat_view = 8'h00;
      stat_view[STAT_MODE_LSB +: 2]  = mode;
      stat_view[STAT_CAUSE_LSB +: 4] = last_wake;
   end

   // Read data is captured in the setup phase so it comes from a flop.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (setup_rd) begin
         if (hit_ctrl) begin
            prdata_o <= {24'h00_0000, ctrl_view};
         end else if (hit_stat) begin
            prdata_o <= {24'h00_0000, stat_view};
         end else begin
            prdata_o <= 32'h0000_0000;
         end
      end
   end

   // Standby select: a 1 is refused while the watchdog runs, a 0 always
   // lands outside standby, so software can back out of standby before it is entered.
   always_ff @(posedge ref_clk_i) begin
      if (hard_reset) begin
         standby_select <= STBY_CTRL_RESET[STBY_SEL_BIT];
      end else if (wr_ctrl) begin
         if (!pwdata_i[STBY_SEL_BIT] || !watchdog_run_enable_i) begin
            standby_select <= pwdata_i[STBY_SEL_BIT];
         end
      end
   end

   // Port float select obeys the same watchdog interlock.
   always_ff @(posedge ref_clk_i) begin
      if (hard_reset) begin
         port_float_select <= STBY_CTRL_RESET[PORT_FLOAT_BIT];
      end else if (wr_ctrl) begin
         if (!pwdata_i[PORT_FLOAT_BIT] || !watchdog_run_enable_i) begin
            port_float_select <= pwdata_i[PORT_FLOAT_BIT];
         end
      end
   end

   // Sleep ends on any qualified cause; standby only on power-on reset,
   // which is already folded into the hard reset.
   assign leave_sleep      = (mode == PDC_SLEEP) && (wake != '0);
   assign enter_power_down = (mode == PDC_RUN) && sleep_req_i;

   // Mode sequencing.
   always_comb begin
      next_mode = mode;
      unique case (mode)
         PDC_RUN: begin
            if (enter_power_down) begin
               // The select bit is sampled in the request cycle.
               next_mode = standby_select ? PDC_STANDBY
                                          : PDC_SLEEP;
            end
         end
         PDC_SLEEP: begin
            if (leave_sleep) begin
               next_mode = PDC_RUN;
            end
         end
         PDC_STANDBY: begin
            next_mode = PDC_STANDBY;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (hard_reset) begin
         mode <= PDC_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   assign mode_o = mode;

   // Exception starts are one-cycle pulses on the sleep exit edge. A wake
   // in run mode is the interrupt controller's business, not ours.
   always_ff @(posedge ref_clk_i) begin
      if (hard_reset) begin
         irq_exc_start_o      <= 1'b0;
         addr_err_exc_start_o <= 1'b0;
      end else begin
         irq_exc_start_o      <= leave_sleep && wake.irq;
         addr_err_exc_start_o <= leave_sleep && wake.addr_err;
      end
   end

   // Reset outputs follow the pins; manual reset is swallowed in standby
   // because the clocks it would need are stopped.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         power_on_reset_o <= 1'b0;
         manual_reset_o   <= 1'b0;
      end else begin
         power_on_reset_o <= wake.power_on;
         manual_reset_o   <= wake.manual
                             && (mode != PDC_STANDBY);
      end
   end

   // Last wake cause: set on each sleep exit, cleared by reading the
   // status register; a new cause in the same cycle wins over the clear.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         last_wake <= 4'h0;
      end else if (leave_sleep) begin
         last_wake <= wake;
      end else if (rd_stat) begin
         last_wake <= 4'h0;
      end
   end

   // Power controls. Sleep only stops the CPU, so its registers and the
   // peripherals keep their state; standby stops everything. RAM writes
   // are blocked in standby so a stopping clock cannot corrupt a word.
   always_ff @(posedge ref_clk_i) begin
      if (hard_reset) begin
         pwr_ctl_o.cpu_halt     <= 1'b0;
         pwr_ctl_o.clk_run      <= 1'b1;
         pwr_ctl_o.periph_run   <= 1'b1;
         pwr_ctl_o.ram_wr_block <= 1'b0;
      end else begin
         pwr_ctl_o.cpu_halt     <= (next_mode != PDC_RUN);
         pwr_ctl_o.clk_run      <= (next_mode != PDC_STANDBY);
         pwr_ctl_o.periph_run   <= (next_mode != PDC_STANDBY);
         pwr_ctl_o.ram_wr_block <= (next_mode == PDC_STANDBY);
      end
   end

   // Port pins hold or float in standby; in sleep they keep following their function.
   pdc_port_ctrl #(
      .WIDTH      (PORT_W)
   ) u_port (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (hard_reset),
      .standby_i  (mode == PDC_STANDBY),
      .float_i    (port_float_select),
      .func_out_i (func_out_i),
      .func_oe_i  (func_oe_i),
      .pad_out_o  (pad_out_o),
      .pad_oe_o   (pad_oe_o)
   );

endmodule // pdc_power_down

// ### shared/pdc_pkg.sv
// Shared constants and types for the power-down mode controller.
package pdc_pkg;

   // Register byte addresses on the APB bus.
   localparam logic [31:0] STBY_CTRL_ADDR  = 32'hFFFF_8614;
   localparam logic [31:0] PWR_STAT_ADDR   = 32'hFFFF_8618;

   // Standby control register layout and reset value.
   localparam int          STBY_SEL_BIT    = 7;
   localparam int          PORT_FLOAT_BIT  = 6;
   localparam logic [7:0]  STBY_CTRL_RESET = 8'h1F;
   localparam logic [7:0]  STBY_RSVD_MASK  = 8'h3F;
   localparam logic [7:0]  STBY_RSVD_VALUE = 8'h1F;

   // Power status register layout.
   localparam int          STAT_MODE_LSB   = 0;
   localparam int          STAT_CAUSE_LSB  = 4;

   // Default widths.
   localparam int          IRQ_LEVEL_W     = 4;
   localparam int          PORT_W          = 16;

   // Power-down modes.
   typedef enum logic [1:0] {
      PDC_RUN,
      PDC_SLEEP,
      PDC_STANDBY
   } pdc_mode_t;

   // Causes that end a power-down mode, highest priority first.
   typedef struct packed {
      logic power_on;
      logic manual;
      logic addr_err;
      logic irq;
   } pdc_wake_t;

   // Power controls handed to the rest of the chip.
   typedef struct packed {
      logic cpu_halt;
      logic clk_run;
      logic periph_run;
      logic ram_wr_block;
   } pdc_pwr_ctl_t;

endpackage

// ### hdl/pdc_wake_detect.sv
// Wake source qualification and priority for the power-down controller.
`timescale 1ns/10ps
module pdc_wake_detect #(
   parameter int LEVEL_W = pdc_pkg::IRQ_LEVEL_W
) (
   // Interrupt request from the interrupt controller
   input  wire logic               irq_req_i,
   input  wire logic [LEVEL_W-1:0] irq_level_i,
   input  wire logic               irq_src_enabled_i,
   input  wire logic [LEVEL_W-1:0] status_mask_i,
   // Transfer address errors
   input  wire logic               mac_addr_err_i,
   input  wire logic               data_transfer_ctrl_err_i,
   // Reset pins
   input  wire logic               power_on_reset_n_i,
   input  wire logic               manual_reset_n_i,
   // Prioritised one-hot cause
   output pdc_pkg::pdc_wake_t      wake_o
);
   import pdc_pkg::*;

   logic irq_ok;
   logic err_any;

   // A request only counts when the source lets it out and it beats the mask.
   assign irq_ok  = irq_req_i && irq_src_enabled_i
                    && (irq_level_i > status_mask_i);
   assign err_any = mac_addr_err_i || data_transfer_ctrl_err_i;

   // Power-on outranks manual reset, which needs the power-on pin high.
   always_comb begin
      wake_o          = '0;
      if (!power_on_reset_n_i) begin
         wake_o.power_on = 1'b1;
      end else if (!manual_reset_n_i) begin
         wake_o.manual   = 1'b1;
      end else if (err_any) begin
         wake_o.addr_err = 1'b1;
      end else if (irq_ok) begin
         wake_o.irq      = 1'b1;
      end
   end

endmodule // pdc_wake_detect

// ### hdl/pdc_port_ctrl.sv
// Standby behaviour of the general I/O port pins: hold or float.
`timescale 1ns/10ps
module pdc_port_ctrl #(
   parameter int WIDTH = pdc_pkg::PORT_W
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   // Mode control
   input  wire logic             standby_i,
   input  wire logic             float_i,
   // Port function side
   input  wire logic [WIDTH-1:0] func_out_i,
   input  wire logic [WIDTH-1:0] func_oe_i,
   // Pad side
   output logic      [WIDTH-1:0] pad_out_o,
   output logic      [WIDTH-1:0] pad_oe_o
);
   import pdc_pkg::*;

   // Each pin follows its function until standby, then the last driven
   // state is frozen; floating overrides the freeze by dropping the enable.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               pad_out_o[g] <= 1'b0;
               pad_oe_o[g]  <= 1'b0;
            end else if (!standby_i) begin
               pad_out_o[g] <= func_out_i[g];
               pad_oe_o[g]  <= func_oe_i[g];
            end else if (float_i) begin
               pad_oe_o[g]  <= 1'b0;
            end
         end
      end
   endgenerate

endmodule // pdc_port_ctrl

// ### bench/pdc_power_down_properties.sv
// Port checker for the power-down mode controller.
`timescale 1ns/10ps
module pdc_power_down_chk
   import pdc_pkg::*;
#(
   parameter int LEVEL_W = IRQ_LEVEL_W
) (
   // Clock and reset
   input wire logic                  ref_clk_i,
   input wire logic                  rst_i,
   // Requests and wake sources
   input wire logic                  sleep_req_i,
   input wire logic [LEVEL_W-1:0]    status_mask_i,
   input wire logic                  irq_req_i,
   input wire logic [LEVEL_W-1:0]    irq_level_i,
   input wire logic                  irq_src_enabled_i,
   input wire logic                  mac_addr_err_i,
   input wire logic                  data_transfer_ctrl_err_i,
   input wire logic                  power_on_reset_n_i,
   input wire logic                  manual_reset_n_i,
   // Observed outputs
   input wire logic                  irq_exc_start_o,
   input wire logic                  addr_err_exc_start_o,
   input wire logic                  power_on_reset_o,
   input wire logic                  manual_reset_o,
   input wire pdc_pkg::pdc_pwr_ctl_t pwr_ctl_o,
   input wire pdc_pkg::pdc_mode_t    mode_o
);
   // Wake terms; a reset pin outranks the others, so they need both high.
   wire logic irq_go = irq_req_i && irq_src_enabled_i
                       && (irq_level_i > status_mask_i);
   wire logic err    = mac_addr_err_i || data_transfer_ctrl_err_i;
   wire logic pins   = power_on_reset_n_i && manual_reset_n_i;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_asleep;
      mode_o == PDC_SLEEP && pins;
   endsequence
   sequence s_awake;
      mode_o == PDC_RUN && !pwr_ctl_o.cpu_halt;
   endsequence

   property p_enter;
      mode_o == PDC_RUN && sleep_req_i && pins |=> mode_o != PDC_RUN;
   endproperty
   property p_sleep_ctl;
      mode_o == PDC_SLEEP |-> pwr_ctl_o == 4'b1110;
   endproperty
   property p_stby_ctl;
      mode_o == PDC_STANDBY |-> pwr_ctl_o == 4'b1001;
   endproperty
   property p_stby_hold;
      mode_o == PDC_STANDBY && power_on_reset_n_i |=> mode_o == PDC_STANDBY;
   endproperty
   property p_irq_wake;
      s_asleep ##0 (irq_go && !err) |=> s_awake ##0 irq_exc_start_o;
   endproperty
   property p_no_wake;
      s_asleep ##0 (!irq_go && !err) |=> mode_o == PDC_SLEEP;
   endproperty
   property p_err_wake;
      s_asleep ##0 err |=> s_awake ##0 addr_err_exc_start_o;
   endproperty
   property p_por;
      !power_on_reset_n_i |=> mode_o == PDC_RUN && power_on_reset_o;
   endproperty
   property p_man;
      mode_o == PDC_SLEEP && power_on_reset_n_i && !manual_reset_n_i
      |=> mode_o == PDC_RUN && manual_reset_o;
   endproperty

   a_enter: assert property (p_enter)
      else $error("sleep request not taken");
   a_sleep_ctl: assert property (p_sleep_ctl)
      else $error("sleep power controls wrong");
   a_stby_ctl: assert property (p_stby_ctl)
      else $error("standby power controls wrong");
   a_stby_hold: assert property (p_stby_hold)
      else $error("standby left without power-on reset");
   a_irq_wake: assert property (p_irq_wake)
      else $error("accepted interrupt did not wake");
   a_no_wake: assert property (p_no_wake)
      else $error("sleep left without cause");
   a_err_wake: assert property (p_err_wake)
      else $error("address error did not wake");
   a_por: assert property (p_por)
      else $error("power-on reset not honoured");
   a_man: assert property (p_man)
      else $error("manual reset did not wake");
endmodule // pdc_power_down_chk

bind pdc_power_down pdc_power_down_chk #(.LEVEL_W(LEVEL_W)) u_chk (
   .ref_clk_i, .rst_i, .sleep_req_i, .status_mask_i, .irq_req_i,
   .irq_level_i, .irq_src_enabled_i, .mac_addr_err_i,
   .data_transfer_ctrl_err_i,
   .power_on_reset_n_i, .manual_reset_n_i, .irq_exc_start_o,
   .addr_err_exc_start_o, .power_on_reset_o, .manual_reset_o,
   .pwr_ctl_o, .mode_o
);

// ### bench/pdc_cpu_model.sv
// Behavioural model of the CPU core, watchdog and reset pins.
`timescale 1ns/10ps
module pdc_cpu_model (
   // Clock
   input  wire logic  ref_clk_i,
   // Drives toward the controller
   output logic       sleep_req_o,
   output logic [3:0] status_mask_o,
   output logic       irq_req_o,
   output logic [3:0] irq_level_o,
   output logic       irq_src_enabled_o,
   output logic       mac_addr_err_o,
   output logic       data_transfer_ctrl_err_o,
   output logic       watchdog_run_enable_o,
   output logic       power_on_reset_n_o,
   output logic       manual_reset_n_o
);
   // Idle at time zero: watchdog stopped, reset pins high.
   initial begin
      sleep_req_o = 1'b0;
      status_mask_o = 4'h2;
      irq_req_o = 1'b0;
      irq_level_o = 4'h5;
      irq_src_enabled_o = 1'b1;
      mac_addr_err_o = 1'b0;
      data_transfer_ctrl_err_o = 1'b0;
      watchdog_run_enable_o = 1'b0;
      power_on_reset_n_o = 1'b1;
      manual_reset_n_o = 1'b1;
   end

   // The sleep instruction lasts one clock.
   task automatic sleep();
      @(posedge ref_clk_i);
      sleep_req_o <= 1'b1;
      @(posedge ref_clk_i);
      sleep_req_o <= 1'b0;
   endtask

   // Software must stop the watchdog before asking for standby.
   task automatic watchdog_run(input logic v);
      @(posedge ref_clk_i);
      watchdog_run_enable_o <= v;
   endtask

   // The status word mask level that an interrupt must beat.
   task automatic mask(input logic [3:0] v);
      @(posedge ref_clk_i);
      status_mask_o <= v;
   endtask

   // One-cycle event: 0 irq, 1 transfer error, 2 manual, 3 masked irq,
   // 4 disabled irq, 5 second transfer error, 6 power-on reset.
   task automatic drive(input int k);
      @(posedge ref_clk_i);
      irq_req_o <= (k == 0 || k == 3 || k == 4);
      irq_level_o <= (k == 3) ? 4'h2 : 4'h5; // Equal to mask: refused.
      irq_src_enabled_o <= (k != 4);
      mac_addr_err_o <= (k == 1);
      data_transfer_ctrl_err_o <= (k == 5);
      manual_reset_n_o <= (k != 2);
      power_on_reset_n_o <= (k != 6);
      @(posedge ref_clk_i);
      irq_req_o <= 1'b0;
      mac_addr_err_o <= 1'b0;
      data_transfer_ctrl_err_o <= 1'b0;
      manual_reset_n_o <= 1'b1;
      power_on_reset_n_o <= 1'b1;
   endtask
endmodule // pdc_cpu_model

// ### bench/pdc_power_down_bench.sv
// Self-checking bench for the power-down mode controller.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module pdc_power_down_bench;
   import pdc_pkg::*;
   logic ref_clk_i, rst_i, psel_i, penable_i, pwrite_i;
   logic [31:0] paddr_i, pwdata_i, prdata_o;
   logic pready_o, pslverr_o, sleep_req_i, irq_exc_start_o;
   logic addr_err_exc_start_o, irq_req_i, irq_src_enabled_i;
   logic mac_addr_err_i, data_transfer_ctrl_err_i, watchdog_run_enable_i;
   logic [3:0] pstrb_i;
   logic power_on_reset_n_i, manual_reset_n_i;
   logic power_on_reset_o, manual_reset_o;
   logic [3:0] status_mask_i, irq_level_i;
   logic [15:0] func_out_i, func_oe_i, pad_out_o, pad_oe_o;
   pdc_pwr_ctl_t pwr_ctl_o;
   pdc_mode_t mode_o;
   int err_count = 0;
   int tests_run = 0;
   logic [3:0] pin_exp [7] = '{4'h8, 4'h4, 4'h1, 4'h0, 4'h0, 4'h4, 4'h2};
   logic [7:0] stat_exp [6] = '{8'h10, 8'h20, 8'h40, 8'h01, 8'h01, 8'h20};

   pdc_power_down u_dut (.ref_clk_i, .rst_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
      .pslverr_o, .sleep_req_i, .status_mask_i, .irq_exc_start_o,
      .addr_err_exc_start_o, .irq_req_i, .irq_level_i, .irq_src_enabled_i,
      .mac_addr_err_i, .data_transfer_ctrl_err_i, .watchdog_run_enable_i,
      .power_on_reset_n_i, .manual_reset_n_i, .power_on_reset_o,
      .manual_reset_o, .pwr_ctl_o, .mode_o, .func_out_i, .func_oe_i,
      .pad_out_o, .pad_oe_o);

   pdc_cpu_model u_cpu (.ref_clk_i, .sleep_req_o(sleep_req_i),
      .status_mask_o(status_mask_i), .irq_req_o(irq_req_i),
      .irq_level_o(irq_level_i), .irq_src_enabled_o(irq_src_enabled_i),
      .mac_addr_err_o(mac_addr_err_i),
      .data_transfer_ctrl_err_o(data_transfer_ctrl_err_i),
      .watchdog_run_enable_o(watchdog_run_enable_i),
      .power_on_reset_n_o(power_on_reset_n_i),
      .manual_reset_n_o(manual_reset_n_i));

   // APB transfer; the wait has no limit of its own, the watchdog cuts it.
   task automatic apb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r, output logic e);
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, {24'h0, x})
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // The run needs well under a thousand cycles.
   initial begin
      #(5000 * 50);
      err_count++;
      test_done();
   end

   initial begin
      logic [31:0] r;
      logic e;
      {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
      paddr_i = 32'h0;
      pwdata_i = 32'h0;
      pstrb_i = 4'hF;
      func_out_i = 16'hA5A5;
      func_oe_i = 16'hFFFF;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(STBY_CTRL_ADDR, 8'h1F);
      // A write without the low byte strobe must leave the register alone.
      pstrb_i <= 4'hE;
      wr(STBY_CTRL_ADDR, 8'hDF);
      pstrb_i <= 4'hF;
      rd(STBY_CTRL_ADDR, 8'h1F);
      wr(STBY_CTRL_ADDR, 8'hDF);
      rd(STBY_CTRL_ADDR, 8'hDF);
      u_cpu.watchdog_run(1'b1);
      wr(STBY_CTRL_ADDR, 8'h1F);
      wr(STBY_CTRL_ADDR, 8'hDF);
      rd(STBY_CTRL_ADDR, 8'h1F);
      apb(1'b0, 32'hFFFF_8610, 32'h0, r, e);
      `CHK(e, 1'b1)
      u_cpu.watchdog_run(1'b0);
      // Every wake cause from sleep, with the two that must not wake at k 3 and 4.
      for (int k = 0; k < 7; k++) begin
         wr(STBY_CTRL_ADDR, 8'h1F);
         u_cpu.sleep();
         @(negedge ref_clk_i);
         `CHK(mode_o, PDC_SLEEP)
         `CHK(pwr_ctl_o, 4'b1110)
         u_cpu.drive(k);
         @(negedge ref_clk_i);
         `CHK({irq_exc_start_o, addr_err_exc_start_o, power_on_reset_o,
               manual_reset_o}, pin_exp[k])
         `CHK(mode_o, (k == 3 || k == 4) ? PDC_SLEEP : PDC_RUN)
         if (k != 6) rd(PWR_STAT_ADDR, stat_exp[k]);
         if (k == 3 || k == 4) begin
            if (k == 3) begin
               // A level equal to a raised mask must not wake either.
               u_cpu.mask(4'h5);
               u_cpu.drive(0);
               @(negedge ref_clk_i);
               `CHK(mode_o, PDC_SLEEP)
               u_cpu.mask(4'h2);
            end
            u_cpu.drive(0);
            rd(PWR_STAT_ADDR, 8'h10);
         end
      end
      // Standby with pins held: only power-on reset ends it.
      wr(STBY_CTRL_ADDR, 8'h9F);
      u_cpu.sleep();
      @(posedge ref_clk_i);
      func_out_i <= 16'h5A5A;
      func_oe_i <= 16'h0F0F;
      repeat (2) @(negedge ref_clk_i);
      `CHK(mode_o, PDC_STANDBY)
      `CHK(pwr_ctl_o, 4'b1001)
      `CHK(pad_out_o, 16'hA5A5)
      `CHK(pad_oe_o, 16'hFFFF)
      // Control writes are ignored once standby is entered.
      wr(STBY_CTRL_ADDR, 8'h1F);
      rd(STBY_CTRL_ADDR, 8'h9F);
      u_cpu.drive(0);
      u_cpu.drive(2);
      @(negedge ref_clk_i);
      `CHK({mode_o, manual_reset_o}, {PDC_STANDBY, 1'b0})
      u_cpu.drive(6);
      @(negedge ref_clk_i);
      `CHK(mode_o, PDC_RUN)
      // Standby with floating pins.
      wr(STBY_CTRL_ADDR, 8'hDF);
      u_cpu.sleep();
      repeat (2) @(negedge ref_clk_i);
      `CHK(pad_oe_o, 16'h0000)
      u_cpu.drive(6);
      rd(STBY_CTRL_ADDR, 8'h1F);
      test_done();
   end
endmodule // pdc_power_down_bench
